/* File: core/gyro_spi_pkg.sv */
package gyro_spi_pkg;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS = 6;
    localparam int BYTE_BITS = 8;
    localparam int BIT_CNT_W = 5;
    localparam logic [4:0] LAST_BIT = 5'h0F;
    localparam int WR_BIT = 15;
    localparam int ZERO_BIT = 14;
    localparam int ADDR_MSB = 13;
    localparam int ADDR_LSB = 8;
    // ------------------------------------------------------------
    // Output register word addresses (upper byte address drops bit 0)
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_FLASH_COUNT = 6'h00;
    localparam logic [5:0] ADDR_SUPPLY = 6'h02;
    localparam logic [5:0] ADDR_RATE = 6'h04;
    localparam logic [5:0] ADDR_AUX = 6'h0A;
    localparam logic [5:0] ADDR_TEMP = 6'h0C;
    localparam logic [5:0] ADDR_ANGLE = 6'h0E;
    localparam logic [5:0] ADDR_CTRL_FIRST = 6'h14;
    localparam int NUM_CTRL = 22;
    // ------------------------------------------------------------
    // Output word fields
    // ------------------------------------------------------------
    localparam int FRESH_BIT = 15;
    localparam int ALARM_BIT = 14;
    localparam int WIDE_W = 14;
    localparam int NARROW_W = 12;
    localparam logic [13:0] RATE_POS_MAX = 14'h1FFF;
    localparam logic [13:0] RATE_NEG_MIN = 14'h2000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    // Link clock divider: half period in sys_clk cycles
    localparam int SCLK_HALF_CYC = 4;
    // Output channels tracked for fresh data
    localparam int NUM_OUT = 5;
endpackage

/* File: core/gyro_spi_if.sv */
interface gyro_spi_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout;
    logic dout_oe;
    modport device (input cs_n, input sclk, input din, output dout, output dout_oe);
    modport master (output cs_n, output sclk, output din, input dout, input dout_oe);
endinterface

/* File: core/gyro_spi_device.sv */
// Functional notes
// - Registers 16 bits, two 6-bit byte addresses
// - Chip select high: output off, inputs ignored
// - Master frames transfers with chip select low
// - Frame is 16 clocks, full duplex
// - Write: 1, 0, address, data byte
// - One write frame changes one byte
// - Read: 00, address, eight don't-care bits
// - Either byte address returns full word
// - Read data shifts out next frame
// - Output data refreshed at own rate
// - Bit 15 fresh flag, cleared on read
// - Bit 14 error/alarm flag
// - Values in bits 13..0 or 11..0
// - Flash count is plain 16-bit count
// - Rate 14-bit two's complement, saturated
// - Aux input 12-bit at 0x0B/0x0A
// - Master configures via control byte writes
// - Angle integrates rate, cleared on null/reset
module gyro_spi_device #(
    parameter int CTRL_REGS = gyro_spi_pkg::NUM_CTRL
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Serial link
    gyro_spi_if.device spi,
    // Sensor side
    input wire logic sample_stb,
    input wire logic [15:0] rate_raw,
    input wire logic [11:0] supply_raw,
    input wire logic [11:0] temp_raw,
    input wire logic [11:0] aux_raw,
    input wire logic [15:0] flash_count,
    input wire logic alarm_in,
    input wire logic null_cmd,
    // Control write strobe to the rest of the chip
    output logic wr_stb,
    output logic [5:0] wr_addr,
    output logic [7:0] wr_data
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] cs_s_r, sclk_s_r, din_s_r;
    logic sclk_d_r;
    // Second stage only feeds logic
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cs_s_r <= 2'h3;
            sclk_s_r <= 2'h3;
            din_s_r <= 2'h0;
            sclk_d_r <= 1'b1;
        end else begin
            cs_s_r <= {cs_s_r[0], spi.cs_n};
            sclk_s_r <= {sclk_s_r[0], spi.sclk};
            din_s_r <= {din_s_r[0], spi.din};
            sclk_d_r <= sclk_s_r[1];
        end
    end

    logic sel, rise, fall;
    assign sel = !cs_s_r[1];
    assign rise = sel && sclk_s_r[1] && !sclk_d_r;
    assign fall = sel && !sclk_s_r[1] && sclk_d_r;

    // ------------------------------------------------------------
    // Output data registers
    // ------------------------------------------------------------
    logic [13:0] rate_r, angle_r;
    logic [11:0] supply_r, temp_r, aux_r;
    logic [gyro_spi_pkg::NUM_OUT-1:0] fresh_r;
    logic [gyro_spi_pkg::NUM_OUT-1:0] read_clr;
    logic [13:0] rate_sat;

    // Saturate 16-bit signed raw rate to 14 bits
    always_comb begin
        if (!rate_raw[15] && rate_raw[14:13] != 2'h0)
            rate_sat = gyro_spi_pkg::RATE_POS_MAX;
        else if (rate_raw[15] && rate_raw[14:13] != 2'h3)
            rate_sat = gyro_spi_pkg::RATE_NEG_MIN;
        else
            rate_sat = rate_raw[13:0];
    end

    // Sample capture independent of reads
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rate_r <= 14'h0000;
            supply_r <= 12'h000;
            temp_r <= 12'h000;
            aux_r <= 12'h000;
        end else if (sample_stb) begin
            rate_r <= rate_sat;
            supply_r <= supply_raw;
            temp_r <= temp_raw;
            aux_r <= aux_raw;
        end
    end

    // Angle integrator; wraps, so hosts take differences
    always_ff @(posedge sys_clk) begin
        if (!rst_n || null_cmd)
            angle_r <= 14'h0000;
        else if (sample_stb)
            angle_r <= angle_r + rate_sat;
    end

    // Per-register fresh flags; a new sample wins over a read
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            fresh_r <= '0;
        else if (sample_stb)
            fresh_r <= '1;
        else
            fresh_r <= fresh_r & ~read_clr;
    end

    // ------------------------------------------------------------
    // Frame shifter
    // ------------------------------------------------------------
    logic [4:0] bit_cnt_r;
    logic [15:0] rx_r, tx_r;
    logic [15:0] rx_full;
    logic dout_r, oe_r;
    logic [5:0] rd_addr;
    logic [15:0] rd_word;
    logic frame_end;
    assign rx_full = {rx_r[14:0], din_s_r[1]};
    assign frame_end = rise && bit_cnt_r == gyro_spi_pkg::LAST_BIT;
    assign rd_addr = {rx_full[gyro_spi_pkg::ADDR_MSB:gyro_spi_pkg::ADDR_LSB+1], 1'b0};

    // Word returned for a read request
    always_comb begin
        read_clr = '0;
        unique case (rd_addr)
            gyro_spi_pkg::ADDR_FLASH_COUNT: rd_word = flash_count;
            gyro_spi_pkg::ADDR_SUPPLY: begin
                rd_word = {fresh_r[0], alarm_in, 2'h0, supply_r};
                read_clr[0] = 1'b1;
            end
            gyro_spi_pkg::ADDR_RATE: begin
                rd_word = {fresh_r[1], alarm_in, rate_r};
                read_clr[1] = 1'b1;
            end
            gyro_spi_pkg::ADDR_AUX: begin
                rd_word = {fresh_r[2], alarm_in, 2'h0, aux_r};
                read_clr[2] = 1'b1;
            end
            gyro_spi_pkg::ADDR_TEMP: begin
                rd_word = {fresh_r[3], alarm_in, 2'h0, temp_r};
                read_clr[3] = 1'b1;
            end
            gyro_spi_pkg::ADDR_ANGLE: begin
                rd_word = {fresh_r[4], alarm_in, angle_r};
                read_clr[4] = 1'b1;
            end
            default: rd_word = gyro_spi_pkg::WORD_ZERO;
        endcase
        // Only a completed read frame clears a flag
        if (!(frame_end && !rx_full[gyro_spi_pkg::WR_BIT]))
            read_clr = '0;
    end

    // Bit counter, restarts on every chip select
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !sel)
            bit_cnt_r <= 5'h00;
        else if (frame_end)
            bit_cnt_r <= 5'h00;
        else if (rise)
            bit_cnt_r <= bit_cnt_r + 5'h01;
    end

    // Receive shifter, MSB first on rising edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            rx_r <= 16'h0000;
        else if (rise)
            rx_r <= rx_full;
    end

    // Transmit: load next word at frame end, shift on falling edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_r <= 16'h0000;
            dout_r <= 1'b0;
        end else if (frame_end) begin
            tx_r <= rx_full[gyro_spi_pkg::WR_BIT] ? gyro_spi_pkg::WORD_ZERO : rd_word;
        end else if (fall) begin
            dout_r <= tx_r[gyro_spi_pkg::FRAME_BITS-1];
            tx_r <= {tx_r[14:0], 1'b0};
        end
    end

    // Drive the output only while selected
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            oe_r <= 1'b0;
        else
            oe_r <= sel;
    end
    assign spi.dout = dout_r;
    assign spi.dout_oe = oe_r;

    // Write strobe: one byte per frame
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_stb <= 1'b0;
            wr_addr <= 6'h00;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= frame_end && rx_full[gyro_spi_pkg::WR_BIT] && !rx_full[gyro_spi_pkg::ZERO_BIT];
            if (frame_end) begin
                wr_addr <= rx_full[gyro_spi_pkg::ADDR_MSB:gyro_spi_pkg::ADDR_LSB];
                wr_data <= rx_full[gyro_spi_pkg::BYTE_BITS-1:0];
            end
        end
    end
endmodule // gyro_spi_device

/* File: core/gyro_spi_master.sv */
module gyro_spi_master (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Serial link
    gyro_spi_if.master spi,
    // User request
    input wire logic req_valid,
    input wire logic [15:0] req_word,
    input wire logic keep_cs,
    output logic req_ready,
    // Received word
    output logic rsp_valid,
    output logic [15:0] rsp_word
);
    typedef enum logic [1:0] {IDLE, LOW, HIGH} mst_state_t;
    mst_state_t state_r;
    logic [2:0] div_r;
    logic [4:0] cnt_r;
    logic [15:0] tx_r, rx_r;
    logic cs_r, sclk_r, din_r, keep_r;
    logic [1:0] dout_s_r;
    logic [1:0] cap_r, last_r;
    logic half_done, rise_go;
    assign half_done = div_r == 3'(gyro_spi_pkg::SCLK_HALF_CYC - 1);
    assign rise_go = state_r == HIGH && half_done;

    // Sample device output through two flops
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            dout_s_r <= 2'h0;
        else
            dout_s_r <= {dout_s_r[0], spi.dout};
    end

    // Frame engine: clock idles high, MSB first
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= IDLE;
            div_r <= 3'h0;
            cnt_r <= 5'h00;
            tx_r <= 16'h0000;
            cs_r <= 1'b1;
            sclk_r <= 1'b1;
            din_r <= 1'b0;
            keep_r <= 1'b0;
            req_ready <= 1'b0;
        end else begin
            req_ready <= 1'b0;
            unique case (state_r)
                IDLE: begin
                    if (!keep_r)
                        cs_r <= 1'b1;
                    if (req_valid && !req_ready) begin
                        req_ready <= 1'b1;
                        tx_r <= req_word;
                        din_r <= req_word[15];
                        keep_r <= keep_cs;
                        cs_r <= 1'b0;
                        cnt_r <= 5'h00;
                        div_r <= 3'h0;
                        state_r <= LOW;
                    end
                end
                LOW: begin
                    div_r <= half_done ? 3'h0 : div_r + 3'h1;
                    if (half_done) begin
                        sclk_r <= 1'b0;
                        din_r <= tx_r[15];
                        tx_r <= {tx_r[14:0], 1'b0};
                        state_r <= HIGH;
                    end
                end
                HIGH: begin
                    div_r <= half_done ? 3'h0 : div_r + 3'h1;
                    if (half_done) begin
                        sclk_r <= 1'b1;
                        cnt_r <= cnt_r + 5'h01;
                        state_r <= (cnt_r == gyro_spi_pkg::LAST_BIT) ? IDLE : LOW;
                    end
                end
            endcase
        end
    end
    assign spi.cs_n = cs_r;
    assign spi.sclk = sclk_r;
    assign spi.din = din_r;

    // Capture lags each rise by the two dout flops, so a bit is taken once it has crossed
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cap_r <= 2'h0;
            last_r <= 2'h0;
        end else begin
            cap_r <= {cap_r[0], rise_go};
            last_r <= {last_r[0], rise_go && cnt_r == gyro_spi_pkg::LAST_BIT};
        end
    end

    // Receive shifter and the word handed back at frame end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_r <= 16'h0000;
            rsp_valid <= 1'b0;
            rsp_word <= 16'h0000;
        end else begin
            rsp_valid <= last_r[1];
            if (cap_r[1])
                rx_r <= {rx_r[14:0], dout_s_r[1]};
            if (last_r[1])
                rsp_word <= {rx_r[14:0], dout_s_r[1]};
        end
    end
endmodule // gyro_spi_master

/* File: verif/gyro_spi_checker.sv */
module gyro_spi_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link wires
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    // ----------------------------------------
    // Link clock rises within one selection
    // ----------------------------------------
    logic [7:0] rises_r;
    logic sclk_d_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Previous link clock level
    always_ff @(posedge sys_clk) begin
        sclk_d_r <= sclk;
    end
    // Cleared while deselected, so chained frames add up
    always_ff @(posedge sys_clk) begin
        if (!rst_n || cs_n) begin
            rises_r <= 8'h00;
        end else if (sclk && !sclk_d_r) begin
            rises_r <= rises_r + 8'h01;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    // Synchronised select needs three cycles to drop the enable
    property p_quiet_off; cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) |-> !dout_oe; endproperty
    property p_idle_high; cs_n && $past(cs_n) |-> sclk; endproperty
    property p_frame_len; $rose(cs_n) |-> rises_r[3:0] == 4'h0 && rises_r != 8'h00; endproperty
    property p_drive_on; $fell(cs_n) |-> ##[1:4] dout_oe; endproperty
    property p_start_high; $fell(cs_n) |-> sclk [*4]; endproperty
    property p_low_half; $fell(sclk) |-> !sclk [*4] ##1 sclk; endproperty
    // Mid-frame high phase: only the falling edge may move data
    property p_dout_hold; sclk && $past(sclk) && !cs_n && rises_r[3:0] != 4'h0 |-> $stable(dout); endproperty
    // Input bit must also hold across the rise that samples it
    property p_din_hold; sclk && !cs_n && rises_r[3:0] != 4'h0 |-> $stable(din); endproperty
    a_quiet_off: assert property (p_quiet_off) else $error("dout driven while deselected");
    a_idle_high: assert property (p_idle_high) else $error("link clock not idle high");
    a_frame_len: assert property (p_frame_len) else $error("frame not a multiple of 16 clocks");
    a_drive_on: assert property (p_drive_on) else $error("dout not driven in frame");
    a_start_high: assert property (p_start_high) else $error("clock fell too soon after select");
    a_low_half: assert property (p_low_half) else $error("link clock low phase not 4 cycles");
    a_dout_hold: assert property (p_dout_hold) else $error("dout moved in high phase");
    a_din_hold: assert property (p_din_hold) else $error("din moved in high phase");
    c_frame_end: cover property ($rose(cs_n));
    c_chained: cover property (!cs_n && rises_r == 8'h20);
    c_data_one: cover property (dout_oe && dout);
endmodule // gyro_spi_checker

/* File: verif/tb_gyro_spi_register_port.sv */
module tb_gyro_spi_register_port;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Stimulus and the two joined ends
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sample_stb = 1'b0;
    logic null_cmd = 1'b0;
    logic alarm_in = 1'b0;
    logic req_valid = 1'b0;
    logic keep_cs = 1'b0;
    logic sclk_q = 1'b1;
    logic [15:0] rate_raw = 16'h7000;
    logic [15:0] flash_count = 16'h5AC3;
    logic [11:0] supply_raw = 12'hABC;
    logic [11:0] temp_raw = 12'h876;
    logic [11:0] aux_raw = 12'h0F1;
    logic [15:0] req_word = 16'h0000;
    logic [15:0] din_sh = 16'h0000;
    logic [15:0] dout_sh = 16'h0000;
    logic req_ready, rsp_valid, wr_stb;
    logic [15:0] rsp_word;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    int errors = 0, n_checks = 0, cycles = 0, strobes = 0;
    always #5 sys_clk = ~sys_clk;
    gyro_spi_if spi_bus ();
    gyro_spi_device gyro_spi_device_inst (.sys_clk(sys_clk), .rst_n(rst_n), .spi(spi_bus), .sample_stb(sample_stb),
        .rate_raw(rate_raw), .supply_raw(supply_raw), .temp_raw(temp_raw), .aux_raw(aux_raw),
        .flash_count(flash_count), .alarm_in(alarm_in), .null_cmd(null_cmd), .wr_stb(wr_stb),
        .wr_addr(wr_addr), .wr_data(wr_data));
    gyro_spi_master gyro_spi_master_inst (.sys_clk(sys_clk), .rst_n(rst_n), .spi(spi_bus), .req_valid(req_valid),
        .req_word(req_word), .keep_cs(keep_cs), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_word(rsp_word));
    gyro_spi_checker gyro_spi_checker_inst (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(spi_bus.cs_n),
        .sclk(spi_bus.sclk), .din(spi_bus.din), .dout(spi_bus.dout), .dout_oe(spi_bus.dout_oe));
    // Wire capture at each link clock rise, strobe count, run limit
    always @(posedge sys_clk) begin
        sclk_q <= spi_bus.sclk;
        if (spi_bus.sclk && !sclk_q && !spi_bus.cs_n) begin
            din_sh <= {din_sh[14:0], spi_bus.din};
            dout_sh <= {dout_sh[14:0], spi_bus.dout};
        end
        if (wr_stb === 1'b1) strobes <= strobes + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            print_verdict();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One frame: hold the request until taken, wait for the answer
    task automatic xfer(input logic [15:0] word, input logic keep, output logic [15:0] got);
        int n;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_word <= word;
        keep_cs <= keep;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 300);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        got = rsp_word;
        check("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
        check("din bits", word, din_sh);
    endtask
    task automatic wr_one(input logic [5:0] a, input logic [7:0] d, input logic keep);
        int s0, n;
        logic [15:0] got;
        s0 = strobes;
        xfer({2'b10, a, d}, keep, got);
        n = 0;
        while (strobes == s0 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        check("strobe count", 16'h0001, 16'(strobes - s0));
        check("wr_addr", {10'h000, a}, {10'h000, wr_addr});
        check("wr_data", {8'h00, d}, {8'h00, wr_data});
    endtask
    // Pipelined reads: each answer arrives in the following frame
    task automatic rd_run(input logic [5:0] a [6], input logic [15:0] e [6], input logic [15:0] m [6]);
        int s0;
        logic [15:0] got;
        s0 = strobes;
        for (int i = 0; i <= 6; i++) begin
            xfer({2'b00, (i < 6) ? a[i] : 6'h3C, 8'h5A}, i < 6, got);
            if (i > 0) begin
                check($sformatf("read %h", a[i-1]), e[i-1] & m[i-1], got & m[i-1]);
                check("dout bits", e[i-1] & m[i-1], dout_sh & m[i-1]);
            end
        end
        check("strobes on reads", 16'h0000, 16'(strobes - s0));
    endtask
    task automatic load(input logic [15:0] rate, input logic alarm);
        @(posedge sys_clk);
        rate_raw <= rate;
        alarm_in <= alarm;
        sample_stb <= 1'b1;
        @(posedge sys_clk);
        sample_stb <= 1'b0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_write_bytes();
        wr_one(6'h15, 8'hA5, 1'b1);
        wr_one(6'h14, 8'h3C, 1'b0);
    endtask
    // Null between two samples leaves the angle at one step
    task automatic t_first_sample();
        load(16'h7000, 1'b0);
        @(posedge sys_clk);
        null_cmd <= 1'b1;
        @(posedge sys_clk);
        null_cmd <= 1'b0;
        load(16'h7000, 1'b0);
        rd_run('{6'h00, 6'h03, 6'h04, 6'h0B, 6'h0E, 6'h3C},
            '{16'h5AC3, 16'h8ABC, 16'h9FFF, 16'h80F1, 16'h9FFF, 16'h0000},
            '{16'hFFFF, 16'hCFFF, 16'hFFFF, 16'hCFFF, 16'hFFFF, 16'hFFFF});
    endtask
    task automatic t_fresh_per_reg();
        rd_run('{6'h0D, 6'h05, 6'h3C, 6'h3C, 6'h3C, 6'h3C},
            '{16'h8876, 16'h1FFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000},
            '{16'hCFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF});
    endtask
    task automatic t_neg_alarm();
        load(16'h8000, 1'b1);
        rd_run('{6'h04, 6'h0F, 6'h02, 6'h0A, 6'h0C, 6'h01},
            '{16'hE000, 16'hFFFF, 16'hCABC, 16'hC0F1, 16'hC876, 16'h5AC3},
            '{16'hFFFF, 16'hFFFF, 16'hCFFF, 16'hCFFF, 16'hCFFF, 16'hFFFF});
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_write_bytes();
        t_first_sample();
        t_fresh_per_reg();
        t_neg_alarm();
        print_verdict();
    end
endmodule // tb_gyro_spi_register_port
